// file: core/adc_fmt_params.svh
// Constants of the converter result and reference block.
// Assumes an 8-bit register port with a 4-bit word address.
`ifndef ADC_FMT_PARAMS_SVH
`define ADC_FMT_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RA_INSEL     4'h0
`define RA_CTRL_A    4'h1
`define RA_CTRL_B    4'h2
`define RA_RES_LOW   4'h3
`define RA_RES_HIGH  4'h4
`define RA_IRQ_STAT  4'h5
`define RA_IRQ_CLR   4'h6
`define RA_IRQ_EN    4'h7

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define BIT_REF_HI     7
`define BIT_REF_LO     6
`define BIT_LEFT_ADJ   5
`define BIT_CONV_EN    7
`define BIT_DONE_A     4
`define BIT_BIPOLAR    7
`define BIT_REF_OUT_EN 1
`define BIT_CH_DIFF    4
`define EV_DONE        0
`define EV_SAT         1
`define CH_TEMP        5'h0B
`define RST_BYTE       8'h00
`define RST_IRQ        2'h0

`endif

// file: core/adc_fmt_pkg.sv
// Types shared by the result formatting block.
// Assumes the constants header is included by the design files.
package adc_fmt_pkg;

	// Result encoding chosen from channel and polarity setting.
	typedef enum logic [1:0]
	{
		MODE_SINGLE  = 2'b00,
		MODE_UNIPOL  = 2'b01,
		MODE_BIPOL   = 2'b10
	} conv_mode_type;

	// Formatted code together with its saturation flag.
	typedef struct packed
	{
		logic [9:0] code;
		logic       saturated;
	} fmt_result_type;

endpackage

// file: core/fmt_if.sv
// Bundle between the register core and the code formatter.
// Assumes both ends share one clock; the bundle is combinational.
`timescale 1ns/10ps
`default_nettype none

interface fmt_if;
	logic signed [15:0]         ratio;     // Sampled input over reference, Q2.14.
	adc_fmt_pkg::conv_mode_type mode;      // Encoding to apply.
	logic                       gain_20x;  // High gain selected.
	adc_fmt_pkg::fmt_result_type result;   // Formatted code and saturation.

	// Register core drives the inputs of the formatter.
	modport ctl (output ratio, output mode, output gain_20x, input result);
	// Formatter answers with the code.
	modport fmt (input ratio, input mode, input gain_20x, output result);
endinterface

`default_nettype wire

// file: core/result_formatter.sv
// Turns a sampled ratio into the 10-bit result code.
// Assumes the ratio is held stable while the core samples the answer.
`timescale 1ns/10ps
`default_nettype none

module result_formatter
(
	fmt_if.fmt port  // Ratio in, code out.
);

	// ----------------------------------------
	// Scaling and clamping
	// ----------------------------------------
	// Gain is 1 for single ended, else 8 or 20.
	wire logic signed [20:0] gain_w =
		(port.mode == adc_fmt_pkg::MODE_SINGLE) ? 21'sh0_0001 :
		port.gain_20x ? 21'sh0_0014 : 21'sh0_0008;
	wire logic signed [20:0] ratio_w = 21'(port.ratio);  // Sign extended.
	wire logic signed [20:0] prod_w  = ratio_w * gain_w; // Fits 21 bits.
	// Bipolar halves the scale: 512 instead of 1024 per reference.
	wire logic signed [20:0] scaled_w =
		(port.mode == adc_fmt_pkg::MODE_BIPOL) ? (prod_w >>> 5) : (prod_w >>> 4);

	// Clamp to the range of the active encoding.
	always_comb
	begin
		port.result.saturated = 1'b0;
		port.result.code      = scaled_w[9:0];
		if (port.mode == adc_fmt_pkg::MODE_BIPOL)
		begin
			// Two's complement from 0x200 to 0x1FF.
			if (scaled_w > 21'sh0_01FF)
			begin
				port.result.code      = 10'h1FF;
				port.result.saturated = 1'b1;
			end
			else if (scaled_w < -21'sh0_0200)
			begin
				port.result.code      = 10'h200;
				port.result.saturated = 1'b1;
			end
		end
		else if (scaled_w < 21'sh0_0000)
		begin
			// Negative difference saturates to zero.
			port.result.code      = 10'h000;
			port.result.saturated = 1'b1;
		end
		else if (scaled_w > 21'sh0_03FF)
		begin
			// Above the reference the code pins at full scale.
			port.result.code      = 10'h3FF;
			port.result.saturated = 1'b1;
		end
	end

endmodule // result_formatter

`default_nettype wire

// file: core/ref_output_ctrl.sv
// Drives the internal reference onto the reference output pin.
// Assumes an analog switch follows the enable and the level select.
`timescale 1ns/10ps
`default_nettype none

module ref_output_ctrl
(
	input  wire logic sys_clk,       // Converter clock.
	input  wire logic rstn,          // Asynchronous reset, active low.
	input  wire logic conv_enable,   // Converter turned on.
	input  wire logic out_enable,    // Reference output enable bit.
	input  wire logic ref_hi,        // Reference select, high bit.
	input  wire logic ref_lo,        // Reference select, low bit.
	output logic      pin_oe_n,      // Low while the pin is driven.
	output logic      level_256      // 1 selects 2.56 V, 0 selects 1.1 V.
);

	// Only the internal reference settings may reach the pin.
	wire logic drive_w = conv_enable && out_enable && ref_lo;

	// Registered so the analog switch sees clean levels.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_oe_n  <= 1'b1;
			level_256 <= 1'b0;
		end
		else
		begin
			pin_oe_n  <= !drive_w;
			level_256 <= drive_w && ref_hi;
		end
	end

endmodule // ref_output_ctrl

`default_nettype wire

// file: core/adc_result_core.sv
// Register core: result bytes, mode control, events and reference output.
// Assumes conv_finish and sample_ratio come from the converter sequencer
// on sys_clk, so they are used without synchronisers.
//
// Functional notes
// - Result readable in low/high bytes once done.
// - Single ended: unsigned code, Vin times 1024/Vref.
// - Unipolar differential: gain 8/20, negatives clamp zero.
// - Unipolar by default; bipolar only when bit set.
// - Bipolar: 512 times gain, two's complement code.
// - Bipolar sign sits in result MSB.
// - Temperature channel routes sensor as single ended.
// - Reference output driven only while converter enabled.
// - Output enable zero leaves pin high impedance.
// - Conversion end sets the done flag.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`include "adc_fmt_params.svh"
`timescale 1ns/10ps
`default_nettype none

module adc_result_core
(
	input  wire logic        sys_clk,        // Converter clock, 250 MHz.
	input  wire logic        rstn,           // Asynchronous reset, active low.
	input  wire logic [3:0]  reg_addr,       // Register word address.
	input  wire logic [7:0]  reg_wdata,      // Write data.
	input  wire logic        reg_wr,         // Write strobe.
	input  wire logic        reg_rd,         // Read strobe.
	output logic      [7:0]  reg_rdata,      // Read data, cycle after strobe.
	input  wire logic        conv_finish,    // One-cycle end of conversion.
	input  wire logic [15:0] sample_ratio,   // Signed input over reference.
	output logic      [4:0]  mux_select,     // Channel to the analog mux.
	output logic             temp_sensor_en, // Temperature sensor to the mux.
	output logic             conv_enable,    // Converter turned on.
	output logic             ref_output_pin_oe_n, // Low while driven.
	output logic             ref_level_256,  // Driven level is 2.56 V.
	output logic             irq             // Level interrupt.
);

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	logic [7:0] input_select_reg;   // Reference, adjust, channel.
	logic       conv_enable_reg;    // Converter on.
	logic       bipolar_select_reg; // Bipolar input mode.
	logic       ref_out_en_reg;     // Reference output enable.
	logic [1:0] irq_status_reg;     // Sticky events.
	logic [1:0] irq_enable_reg;     // Event mask.
	logic [9:0] result_reg;         // Latched code.
	logic [7:0] rdata_reg;          // Read data holding stage.

	fmt_if fmt_bus ();  // Bundle to the formatter.

	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	// Write strobes per register.
	wire logic wr_insel_w = reg_wr && (reg_addr == `RA_INSEL);
	wire logic wr_ctrla_w = reg_wr && (reg_addr == `RA_CTRL_A);
	wire logic wr_ctrlb_w = reg_wr && (reg_addr == `RA_CTRL_B);
	wire logic wr_clr_w   = reg_wr && (reg_addr == `RA_IRQ_CLR);
	wire logic wr_en_w    = reg_wr && (reg_addr == `RA_IRQ_EN);

	// Field views of the input select register.
	wire logic [4:0] channel_select = input_select_reg[4:0];
	wire logic       ref_select_hi  = input_select_reg[`BIT_REF_HI];
	wire logic       ref_select_lo  = input_select_reg[`BIT_REF_LO];
	wire logic       left_adjust    = input_select_reg[`BIT_LEFT_ADJ];

	// A channel code with the top bit set is a differential pair.
	wire logic is_diff_w = channel_select[`BIT_CH_DIFF];

	// A finish only counts while the converter is on.
	wire logic finish_w = conv_finish && conv_enable_reg;

	// Encoding follows channel type, then the polarity bit.
	wire adc_fmt_pkg::conv_mode_type mode_w =
		!is_diff_w ? adc_fmt_pkg::MODE_SINGLE :
		bipolar_select_reg ? adc_fmt_pkg::MODE_BIPOL :
		adc_fmt_pkg::MODE_UNIPOL;

	// Events raised by this conversion end.
	wire logic [1:0] event_w =
		{finish_w && fmt_bus.result.saturated, finish_w};

	// Write-one-to-clear mask, gated to the clear register.
	wire logic [1:0] clear_w = wr_clr_w ? reg_wdata[1:0] : `RST_IRQ;

	// Presentation of the result: right or left adjusted.
	wire logic [7:0] res_low_w = left_adjust ?
		{result_reg[1:0], 6'h00} : result_reg[7:0];
	wire logic [7:0] res_high_w = left_adjust ?
		result_reg[9:2] : {6'h00, result_reg[9:8]};

	// Read data multiplexer; unmapped words read zero.
	wire logic [7:0] read_mux_w =
		(reg_addr == `RA_INSEL)    ? input_select_reg :
		(reg_addr == `RA_CTRL_A)   ?
			{conv_enable_reg, 2'h0, irq_status_reg[`EV_DONE], 4'h0} :
		(reg_addr == `RA_CTRL_B)   ?
			{bipolar_select_reg, 5'h00, ref_out_en_reg, 1'b0} :
		(reg_addr == `RA_RES_LOW)  ? res_low_w :
		(reg_addr == `RA_RES_HIGH) ? res_high_w :
		(reg_addr == `RA_IRQ_STAT) ? {6'h00, irq_status_reg} :
		(reg_addr == `RA_IRQ_EN)   ? {6'h00, irq_enable_reg} :
		`RST_BYTE;

	// ----------------------------------------
	// Formatter hookup
	// ----------------------------------------
	assign fmt_bus.ratio    = sample_ratio;
	assign fmt_bus.mode     = mode_w;
	assign fmt_bus.gain_20x = channel_select[0];  // Odd pair codes are 20x.

	// Converts the ratio into the code of the active encoding.
	result_formatter u_fmt
	(
		.port (fmt_bus)
	);

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	// Control bits written by software; all reset to the unipolar,
	// converter-off, pin-released state.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			input_select_reg   <= `RST_BYTE;
			conv_enable_reg    <= 1'b0;
			bipolar_select_reg <= 1'b0;
			ref_out_en_reg     <= 1'b0;
			irq_enable_reg     <= `RST_IRQ;
		end
		else
		begin
			if (wr_insel_w)
				input_select_reg <= reg_wdata;
			if (wr_ctrla_w)
				conv_enable_reg <= reg_wdata[`BIT_CONV_EN];
			if (wr_ctrlb_w)
			begin
				bipolar_select_reg <= reg_wdata[`BIT_BIPOLAR];
				ref_out_en_reg     <= reg_wdata[`BIT_REF_OUT_EN];
			end
			if (wr_en_w)
				irq_enable_reg <= reg_wdata[1:0];
		end
	end

	// ----------------------------------------
	// Result and events
	// ----------------------------------------
	// The code is latched in the same edge that raises the done flag,
	// so a reader that sees the flag always sees the new code.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			result_reg <= 10'h000;
		else if (finish_w)
			result_reg <= fmt_bus.result.code;
	end

	// Sticky events; a set in the clearing cycle wins over the clear.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			irq_status_reg <= `RST_IRQ;
		else
			irq_status_reg <= (irq_status_reg & ~clear_w) | event_w;
	end

	// Read data stand in each cycle after a strobe cycle, zero otherwise.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			rdata_reg <= `RST_BYTE;
		else
			rdata_reg <= reg_rd ? read_mux_w : `RST_BYTE;
	end

	// ----------------------------------------
	// Reference output
	// ----------------------------------------
	// Pin drive follows enable, converter state and reference select.
	ref_output_ctrl u_ref
	(
		.sys_clk     (sys_clk),
		.rstn        (rstn),
		.conv_enable (conv_enable_reg),
		.out_enable  (ref_out_en_reg),
		.ref_hi      (ref_select_hi),
		.ref_lo      (ref_select_lo),
		.pin_oe_n    (ref_output_pin_oe_n),
		.level_256   (ref_level_256)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata      = rdata_reg;
	assign mux_select     = channel_select;
	assign temp_sensor_en = (channel_select == `CH_TEMP);
	assign conv_enable    = conv_enable_reg;
	assign irq            = |(irq_status_reg & irq_enable_reg);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// A counted conversion end raises the done flag next edge.
	a_done_flag_set: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		finish_w |=> irq_status_reg[`EV_DONE])
		else $error("done flag not set after conversion end");

	// A clear in the same cycle as an event does not drop it.
	a_set_beats_clear: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(finish_w && clear_w[`EV_DONE]) |=> irq_status_reg[`EV_DONE])
		else $error("event lost against simultaneous clear");

	// The latched result equals the formatter answer at the end.
	a_result_latched: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		finish_w |=> (result_reg == $past(fmt_bus.result.code)))
		else $error("result not latched at conversion end");

	// Single ended code in range is the ratio scaled by 1024.
	a_single_scale: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(mode_w == adc_fmt_pkg::MODE_SINGLE && sample_ratio < 16'h4000)
		|-> (fmt_bus.result.code == sample_ratio[13:4]))
		else $error("single ended code wrong");

	// Unipolar negative differences read as zero.
	a_unipolar_clamp: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(mode_w == adc_fmt_pkg::MODE_UNIPOL && sample_ratio[15])
		|-> (fmt_bus.result.code == 10'h000 && fmt_bus.result.saturated))
		else $error("negative unipolar not clamped");

	// Bipolar full positive reference with gain saturates high.
	a_bipolar_top: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(mode_w == adc_fmt_pkg::MODE_BIPOL && sample_ratio[15:14] == 2'b01)
		|-> (fmt_bus.result.code == 10'h1FF))
		else $error("bipolar positive clamp wrong");

	// Bipolar sign bit follows the sign of the difference.
	a_bipolar_sign: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(mode_w == adc_fmt_pkg::MODE_BIPOL)
		|-> (fmt_bus.result.code[9] == sample_ratio[15]))
		else $error("bipolar sign bit wrong");

	// Pin stays released one edge after enable or converter is off.
	a_ref_pin_hiz: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(!ref_out_en_reg || !conv_enable_reg) |=> ref_output_pin_oe_n)
		else $error("reference pin driven while disabled");

	// A driven pin carries the level of the reference select.
	a_ref_level: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		!ref_output_pin_oe_n |-> (ref_level_256 == $past(ref_select_hi)))
		else $error("reference output level wrong");

	// Right adjusted high byte keeps bits above nine at zero.
	// The code is taken as it stood at the read, since a finish may land then.
	a_high_byte_zero: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(reg_rd && reg_addr == `RA_RES_HIGH && !left_adjust)
		|=> (reg_rdata[7:2] == 6'h00 && reg_rdata[1:0] == $past(result_reg[9:8])))
		else $error("high result byte upper bits not zero");

	// Right adjusted low byte carries the lower eight code bits.
	a_low_byte_right: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(reg_rd && reg_addr == `RA_RES_LOW && !left_adjust) |=> (reg_rdata == $past(result_reg[7:0])))
		else $error("low result byte wrong");

	// Left adjusted high byte carries the upper eight code bits.
	a_left_high_byte: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(reg_rd && reg_addr == `RA_RES_HIGH && left_adjust) |=> (reg_rdata == $past(result_reg[9:2])))
		else $error("left adjusted high byte wrong");

	// Read data fall back to zero in every cycle without a read.
	a_rdata_idle_zero: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		!reg_rd |=> (reg_rdata == `RST_BYTE))
		else $error("read data not zero outside read");

	// A finish while the converter is off leaves the result alone.
	a_finish_ignored: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(conv_finish && !conv_enable_reg) |=> $stable(result_reg))
		else $error("result changed while converter off");

	// A clamped code raises the saturation event.
	a_sat_event_set: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(finish_w && fmt_bus.result.saturated) |=> irq_status_reg[`EV_SAT])
		else $error("saturation event not set");

	// Single ended input at or above the reference pins at full scale.
	a_single_top: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(mode_w == adc_fmt_pkg::MODE_SINGLE && sample_ratio[15:14] == 2'b01)
		|-> (fmt_bus.result.code == 10'h3FF && fmt_bus.result.saturated))
		else $error("single ended full scale wrong");

	// Bipolar full negative reference with gain saturates low.
	a_bipolar_bottom: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(mode_w == adc_fmt_pkg::MODE_BIPOL && sample_ratio[15:14] == 2'b10)
		|-> (fmt_bus.result.code == 10'h200))
		else $error("bipolar negative clamp wrong");

	// The polarity bit moves only on a write to its register.
	a_bipolar_written: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		!wr_ctrlb_w |=> $stable(bipolar_select_reg))
		else $error("bipolar select changed without write");

	// The temperature channel is always converted single ended.
	a_temp_single: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		temp_sensor_en |-> (mode_w == adc_fmt_pkg::MODE_SINGLE))
		else $error("temperature channel not single ended");

	// All enables set and an internal reference drive the pin next edge.
	a_ref_pin_drive: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(conv_enable_reg && ref_out_en_reg && ref_select_lo) |=> !ref_output_pin_oe_n)
		else $error("reference pin not driven");

	// A reference select without the internal source keeps the pin released.
	a_ref_lo_release: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		!ref_select_lo |=> ref_output_pin_oe_n)
		else $error("reference pin driven without internal source");

	// An enabled done event raises the interrupt next edge.
	a_done_irq: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(finish_w && irq_enable_reg[`EV_DONE]) |=> irq)
		else $error("interrupt not raised on done");

endmodule // adc_result_core

`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the converter result formatting and reference output core.
// Assumes the core's constants header is on the include path and one 250 MHz clock.
`include "adc_fmt_params.svh"
`timescale 1ns/10ps
`default_nettype none

module testbench;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic        sys_clk;      // Converter clock, 4 ns period.
	logic        rstn;         // Reset, active low.
	logic [3:0]  reg_addr;     // Register word address.
	logic [7:0]  reg_wdata;    // Write data.
	logic        reg_wr;       // Write strobe.
	logic        reg_rd;       // Read strobe.
	logic [7:0]  reg_rdata;    // Read data.
	logic        conv_finish;  // End-of-conversion pulse.
	logic [15:0] sample_ratio; // Signed ratio, Q2.14.
	logic [4:0]  mux_select;   // Channel to the mux.
	logic        temp_sensor_en; // Temperature sensor routed.
	logic        conv_enable;  // Converter on.
	logic        ref_oe_n;     // Reference pin released when high.
	logic        ref_level_256; // Reference level select.
	logic        irq;          // Level interrupt.
	int          n_errors;     // Mismatches seen.
	int          total_checks; // Comparisons made.
	int          cycles;       // Clock cycles run.
	logic [7:0]  rv;           // Scratch read value.

	// Ceiling on cycles; the tests need a few hundred.
	localparam int CYCLE_LIMIT = 5000;

	adc_result_core u_dut
	(
		.sys_clk             (sys_clk),
		.rstn                (rstn),
		.reg_addr            (reg_addr),
		.reg_wdata           (reg_wdata),
		.reg_wr              (reg_wr),
		.reg_rd              (reg_rd),
		.reg_rdata           (reg_rdata),
		.conv_finish         (conv_finish),
		.sample_ratio        (sample_ratio),
		.mux_select          (mux_select),
		.temp_sensor_en      (temp_sensor_en),
		.conv_enable         (conv_enable),
		.ref_output_pin_oe_n (ref_oe_n),
		.ref_level_256       (ref_level_256),
		.irq                 (irq)
	);

	// ----------------------------------------
	// Clock and hang guard
	// ----------------------------------------
	// Clock toggles each half period.
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// A hang counts as a mismatch and closes the run.
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles >= CYCLE_LIMIT)
		begin
			n_errors = n_errors + 1;
			conclude();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	// Compares one value and counts it.
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, seen);
			n_errors = n_errors + 1;
		end
	endtask

	// One-cycle write strobe.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
		#1;
	endtask

	// One-cycle read strobe; data is taken in the following cycle only.
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// Reads a register and compares it.
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		rd(a, rv);
		chk($sformatf("register %0h", a), {8'h00, rv}, {8'h00, exp});
	endtask

	// One end-of-conversion pulse with a ratio.
	task automatic conv(input logic [15:0] r);
		@(posedge sys_clk);
		conv_finish  <= 1'b1;
		sample_ratio <= r;
		@(posedge sys_clk);
		conv_finish  <= 1'b0;
		sample_ratio <= ~r;
		#1;
	endtask

	// Checks the right-adjusted result in both bytes.
	task automatic chk_res(input logic [9:0] code);
		rchk(`RA_RES_LOW, code[7:0]);
		rchk(`RA_RES_HIGH, {6'b00_0000, code[9:8]});
	endtask

	// Selects a channel, converts and checks the code.
	task automatic run_case(input logic [7:0] insel, input logic [15:0] r, input logic [9:0] code);
		wr(`RA_INSEL, insel);
		conv(r);
		chk_res(code);
	endtask

	// Waits a few cycles for the registered pin controls.
	task automatic settle();
		repeat (3) @(posedge sys_clk);
		#1;
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Words 0 to 9 read zero after reset, including unmapped ones, and the pin is released.
	task automatic t_reset();
		chk("oe_n", {15'h0, ref_oe_n}, 16'h0001);
		for (int a = 0; a < 10; a++)
			rchk(a[3:0], 8'h00);
		$display("reset test done");
	endtask

	// Single-ended codes, done flag, saturation event, adjust and interrupt masking.
	task automatic t_single();
		wr(`RA_CTRL_A, 8'h80);
		chk("conv_enable", {15'h0, conv_enable}, 16'h0001);
		wr(`RA_IRQ_EN, 8'h03);
		run_case(8'h40, 16'h2000, 10'h200);
		chk("irq", {15'h0, irq}, 16'h0001);
		rchk(`RA_CTRL_A, 8'h90);
		rchk(`RA_IRQ_STAT, 8'h01);
		wr(`RA_IRQ_CLR, 8'h03);
		chk("irq", {15'h0, irq}, 16'h0000);
		run_case(8'h40, 16'h3FF0, 10'h3FF);
		run_case(8'h40, 16'h4000, 10'h3FF);
		rchk(`RA_IRQ_STAT, 8'h03);
		wr(`RA_INSEL, 8'h60);
		rchk(`RA_RES_HIGH, 8'hFF);
		rchk(`RA_RES_LOW, 8'hC0);
		wr(`RA_IRQ_CLR, 8'h03);
		wr(`RA_IRQ_EN, 8'h00);
		run_case(8'h40, 16'h0010, 10'h001);
		chk("irq", {15'h0, irq}, 16'h0000);
		wr(`RA_IRQ_EN, 8'h01);
		chk("irq", {15'h0, irq}, 16'h0001);
		wr(`RA_IRQ_CLR, 8'h01);
		wr(`RA_CTRL_A, 8'h00);
		chk("conv_enable", {15'h0, conv_enable}, 16'h0000);
		conv(16'h1000);
		rchk(`RA_IRQ_STAT, 8'h00);
		chk_res(10'h001);
		wr(`RA_CTRL_A, 8'h80);
		$display("single-ended test done");
	endtask

	// Unipolar differential at both gains, negative input clamps to zero.
	task automatic t_unipolar();
		run_case(8'h10, 16'h0080, 10'h040);
		run_case(8'h11, 16'h0080, 10'h0A0);
		wr(`RA_IRQ_CLR, 8'h03);
		run_case(8'h10, 16'hFF80, 10'h000);
		rchk(`RA_IRQ_STAT, 8'h03);
		wr(`RA_IRQ_CLR, 8'h03);
		$display("unipolar test done");
	endtask

	// Bipolar two's complement codes, both clamp ends and the sign bit.
	task automatic t_bipolar();
		wr(`RA_CTRL_B, 8'h80);
		run_case(8'h10, 16'hFF80, 10'h3E0);
		run_case(8'h10, 16'h1000, 10'h1FF);
		run_case(8'h10, 16'hF000, 10'h200);
		run_case(8'h11, 16'h0010, 10'h00A);
		wr(`RA_CTRL_B, 8'h00);
		run_case(8'h10, 16'hFF80, 10'h000);
		$display("bipolar test done");
	endtask

	// Temperature channel routes the sensor; a neighbour channel does not.
	task automatic t_temp();
		wr(`RA_INSEL, 8'h4B);
		chk("mux", {11'h0, mux_select}, 16'h000B);
		chk("temp_en", {15'h0, temp_sensor_en}, 16'h0001);
		wr(`RA_INSEL, 8'h4C);
		chk("temp_en", {15'h0, temp_sensor_en}, 16'h0000);
		$display("temperature test done");
	endtask

	// Reference pin follows converter enable, output enable and level select.
	task automatic t_ref();
		wr(`RA_CTRL_A, 8'h00);
		wr(`RA_INSEL, 8'hC0);
		wr(`RA_CTRL_B, 8'h02);
		settle();
		chk("oe_n", {15'h0, ref_oe_n}, 16'h0001);
		wr(`RA_CTRL_A, 8'h80);
		settle();
		chk("oe_n", {15'h0, ref_oe_n}, 16'h0000);
		chk("level", {15'h0, ref_level_256}, 16'h0001);
		wr(`RA_INSEL, 8'h80);
		settle();
		chk("oe_n", {15'h0, ref_oe_n}, 16'h0001);
		chk("level", {15'h0, ref_level_256}, 16'h0000);
		wr(`RA_INSEL, 8'h40);
		settle();
		chk("level", {15'h0, ref_level_256}, 16'h0000);
		chk("oe_n", {15'h0, ref_oe_n}, 16'h0000);
		wr(`RA_CTRL_B, 8'h00);
		settle();
		chk("oe_n", {15'h0, ref_oe_n}, 16'h0001);
		$display("reference test done");
	endtask

	// A clear that meets a conversion end leaves the done flag set.
	task automatic t_set_clear();
		wr(`RA_IRQ_CLR, 8'h03);
		@(posedge sys_clk);
		reg_addr     <= `RA_IRQ_CLR;
		reg_wdata    <= 8'h01;
		reg_wr       <= 1'b1;
		conv_finish  <= 1'b1;
		sample_ratio <= 16'h0100;
		@(posedge sys_clk);
		reg_wr       <= 1'b0;
		conv_finish  <= 1'b0;
		#1;
		rchk(`RA_IRQ_STAT, 8'h01);
		chk_res(10'h010);
		$display("set and clear test done");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		rstn = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		conv_finish = 1'b0;
		sample_ratio = 16'h0000;
		n_errors = 0;
		total_checks = 0;
		cycles = 0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_single();
		t_unipolar();
		t_bipolar();
		t_temp();
		t_set_clear();
		t_ref();
		conclude();
	end
endmodule // testbench

`default_nettype wire
